// ===== rtl/fpp_debounce.sv
/*
 * Switch debouncer for the program push button: synchronises the raw pin and
 * emits a single pulse when a press has been steady for the settle time.
 * Assumes an asynchronous button pin on a bouncing contact.
 */
`timescale 1ns/10ps

module fpp_debounce #(
	parameter int SETTLE_CYCLES = fpp_pkg::DEBOUNCE_CYCLES
) (
	input wire logic i_clock, // System clock.
	input wire logic i_rst_b, // Asynchronous reset, active low.
	input wire logic i_button, // Raw switch level, high when pressed.
	output logic o_press // One-cycle pulse on a settled press.
);

	initial begin
		if (SETTLE_CYCLES < 1) begin
			$error("fpp_debounce: SETTLE_CYCLES must be at least one");
		end
	end

	localparam int CW = $clog2(SETTLE_CYCLES + 1);

	logic meta_q;
	logic sync_q;
	logic stable_q;
	logic [CW-1:0] count_q;

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_button;
			sync_q <= meta_q;
		end
	end

	// ****************************************************************
	// Settle filter
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_q <= '0;
			stable_q <= 1'b0;
			o_press <= 1'b0;
		end else begin
			o_press <= 1'b0;
			if (sync_q == stable_q) begin
				count_q <= '0;
			end else if (count_q == CW'(SETTLE_CYCLES - 1)) begin
				count_q <= '0;
				stable_q <= sync_q;
				o_press <= sync_q;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

endmodule : fpp_debounce

// ===== rtl/fpp_pkg.sv
/*
 * Package for the fuse PROM word programmer: timing constants, field widths,
 * sequencer states and the bundled pin groups toward the target PROM.
 * Assumes a 100 MHz system clock driving every register of the design.
 */
package fpp_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_HZ = 100_000_000;
	localparam int STEP_HZ = 10_000;
	localparam int STEP_CYCLES = CLOCK_HZ / STEP_HZ;
	localparam int DEBOUNCE_US = 5_000;
	localparam int DEBOUNCE_CYCLES = (CLOCK_HZ / 1_000_000) * DEBOUNCE_US;

	// ****************************************************************
	// Counter presets
	// ****************************************************************
	localparam int PULSE_STATES = 5;
	localparam logic [2:0] PULSE_PRESET = 3'h4;
	localparam logic [2:0] PULSE_FIRE = 3'h0;
	localparam logic [2:0] PULSE_ENABLE = 3'h2;
	localparam logic [2:0] PULSE_ADVANCE_FROM = 3'h3;
	localparam logic [2:0] PULSE_LAST = 3'h4;
	localparam int WORD_BITS = 8;
	localparam int ADDR_BITS = 10;
	localparam int MIN_PULSES = 1;
	localparam int REC_PULSES = 4;
	localparam int MAX_PULSES = 8;
	localparam logic [3:0] PULSES_RESET = 4'h0;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		FPP_IDLE = 2'b00,
		FPP_RUN = 2'b01,
		FPP_DONE = 2'b10
	} fpp_state_t;

	// ****************************************************************
	// Pins toward the target
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic cs_low_b;
		logic cs_high;
		logic vcc_read_low;
	} fpp_ctrl_t;

	typedef struct packed {
		logic [WORD_BITS-1:0] pulse;
		logic [WORD_BITS-1:0] hold_high;
	} fpp_drive_t;

endpackage : fpp_pkg

// ===== rtl/fpp_programmer.sv
/*
 * Word programmer for fuse-link bipolar PROMs: selects a word, holds the chip
 * deselected, pulses one output at a time and verifies each bit at low supply.
 * Assumes external level shifters turn o_ctrl and o_drive into real voltages.
 */
// Overview of operation
// - The word address is presented before any fuse pulse is applied.
// - Chip held deselected while pulsing: low selects high, high selects low.
// - A fuse pulse goes only to the output pin of the bit being blown.
// - Never more than one output pulsed at once; bits go one by one.
// - Verify: end pulse, lower supply, enable selects, expect the output low.
// - Repeat the sequence for each bit to become low; skip high bits.
// - Pulse duty cycle stays at or below twenty percent.
// - Each bit gets between one and eight pulses; four recommended; the code gives each blow bit one pulse per press.
// - Before running, indicators show the word; lit when high or deselected.
// - Debounced press sets run; run enables both counters and programming.
// - Pulse counter runs five states per bit; one state pulses.
// - Bit counter covers eight outputs, scanning each in order.
// - Bit counter advances only when the pulse counter moves three to four.
// - Decoded bit line combined with the pattern switch picks pulsed bits.
// - After the last bit counters reload and run clears, ending the word.
// - Counters step from a free-running ten kilohertz tick.
// - On a board only chip select and outputs are used, one via decoder.
`timescale 1ns/10ps

module fpp_programmer #(
	parameter int STEP_CYCLES = fpp_pkg::STEP_CYCLES,
	parameter int SETTLE_CYCLES = fpp_pkg::DEBOUNCE_CYCLES,
	parameter int PULSE_LIMIT = fpp_pkg::REC_PULSES,
	parameter int DEVICES = 4
) (
	input wire logic i_clock, // System clock, 100 MHz.
	input wire logic i_rst_b, // Asynchronous reset, active low.
	input wire logic i_program_sw, // Program push button, high when pressed.
	input wire logic [fpp_pkg::ADDR_BITS-1:0] i_addr_sw, // Word address switches.
	input wire logic [fpp_pkg::WORD_BITS-1:0] i_pattern_sw, // Bit switches, 0 = blow.
	input wire logic [$clog2(DEVICES)-1:0] i_device_sw, // Board device choice.
	input wire logic [fpp_pkg::WORD_BITS-1:0] i_prom_out, // Target outputs.
	output fpp_pkg::fpp_ctrl_t o_ctrl, // Address, selects and supply level.
	output logic [DEVICES-1:0] o_device_sel_b, // Decoded device selects, low.
	output fpp_pkg::fpp_drive_t o_drive, // Per-output pulse and pull-high.
	output logic [fpp_pkg::WORD_BITS-1:0] o_indicator, // Word display lamps.
	output logic o_running, // Run flip-flop.
	output logic o_fail // Bit failed after its one pulse; never sets when PULSE_LIMIT exceeds one.
);

	initial begin
		if (PULSE_LIMIT < fpp_pkg::MIN_PULSES || PULSE_LIMIT > fpp_pkg::MAX_PULSES) begin
			$error("fpp_programmer: PULSE_LIMIT out of range");
		end
		if (STEP_CYCLES < 4) begin
			$error("fpp_programmer: STEP_CYCLES must cover the output sense delay of four");
		end
		if (DEVICES < 2 || DEVICES > fpp_pkg::WORD_BITS) begin
			$error("fpp_programmer: DEVICES must lie between two and the word width");
		end
	end

	localparam int SW = $clog2(STEP_CYCLES);
	localparam int BW = $clog2(fpp_pkg::WORD_BITS);
	localparam int DW = $clog2(DEVICES);

	// Decodes an index into a one-hot line; used for bits and devices.
	function automatic logic [fpp_pkg::WORD_BITS-1:0] one_hot(input logic [BW-1:0] idx);
		logic [fpp_pkg::WORD_BITS-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction : one_hot

	logic press;
	logic [SW-1:0] tick_cnt_q;
	logic tick;
	logic [fpp_pkg::WORD_BITS-1:0] out_meta_q;
	logic [fpp_pkg::WORD_BITS-1:0] out_sync_q;
	fpp_pkg::fpp_state_t state_q;
	logic [2:0] pulse_q;
	logic [BW-1:0] bit_q;
	logic [3:0] pulses_q;
	logic bit_done_q;
	logic fail_q;
	logic [fpp_pkg::ADDR_BITS-1:0] addr_q;
	logic [DW-1:0] dev_q;
	logic [fpp_pkg::WORD_BITS-1:0] pattern_q;
	logic [fpp_pkg::WORD_BITS-1:0] bit_line;
	logic blow_this;
	logic fire;
	logic verify_phase;
	logic deselect;
	logic [fpp_pkg::ADDR_BITS-1:0] addr_meta_q;
	logic [fpp_pkg::ADDR_BITS-1:0] addr_sync_q;
	logic [fpp_pkg::WORD_BITS-1:0] pattern_meta_q;
	logic [fpp_pkg::WORD_BITS-1:0] pattern_sync_q;
	logic [DW-1:0] dev_meta_q;
	logic [DW-1:0] dev_sync_q;

	fpp_debounce #(
		.SETTLE_CYCLES(SETTLE_CYCLES)
	) u_debounce (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_button(i_program_sw),
		.o_press(press)
	);

	// ****************************************************************
	// Free-running step oscillator
	// ****************************************************************
	// The tick runs free of the run flip-flop, so the first state of a run
	// is cut short; that state never carries a pulse.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end
	assign tick = (tick_cnt_q == SW'(STEP_CYCLES - 1));

	// ****************************************************************
	// Output sense synchroniser
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			out_meta_q <= '1;
			out_sync_q <= '1;
		end else begin
			out_meta_q <= i_prom_out;
			out_sync_q <= out_meta_q;
		end
	end

	// ****************************************************************
	// Switch synchronisers
	// ****************************************************************
	// The switches are hand-set levels that may still move at any moment,
	// so they pass two flops before the word latch reads them.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_meta_q <= '0;
			addr_sync_q <= '0;
			pattern_meta_q <= '1;
			pattern_sync_q <= '1;
			dev_meta_q <= '0;
			dev_sync_q <= '0;
		end else begin
			addr_meta_q <= i_addr_sw;
			addr_sync_q <= addr_meta_q;
			pattern_meta_q <= i_pattern_sw;
			pattern_sync_q <= pattern_meta_q;
			dev_meta_q <= i_device_sw;
			dev_sync_q <= dev_meta_q;
		end
	end

	// ****************************************************************
	// Run flip-flop and word latch
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= fpp_pkg::FPP_IDLE;
			addr_q <= '0;
			dev_q <= '0;
			pattern_q <= '1;
		end else begin
			unique case (state_q)
				fpp_pkg::FPP_IDLE: begin
					addr_q <= addr_sync_q;
					dev_q <= dev_sync_q;
					if (press) begin
						pattern_q <= pattern_sync_q;
						state_q <= fpp_pkg::FPP_RUN;
					end
				end
				fpp_pkg::FPP_RUN: begin
					if (tick && pulse_q == fpp_pkg::PULSE_ADVANCE_FROM
						&& bit_q == BW'(fpp_pkg::WORD_BITS - 1)) begin
						state_q <= fpp_pkg::FPP_DONE;
					end
				end
				fpp_pkg::FPP_DONE: begin
					if (!press) begin
						state_q <= fpp_pkg::FPP_IDLE;
					end
				end
				default: begin
					state_q <= fpp_pkg::FPP_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Pulse and bit counters
	// ****************************************************************
	// The preset is the last frame state, so every bit gets a deselected state
	// before its pulse, cut short for the first bit, and a pulse of full width.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pulse_q <= fpp_pkg::PULSE_PRESET;
			bit_q <= '0;
		end else if (state_q != fpp_pkg::FPP_RUN) begin
			pulse_q <= fpp_pkg::PULSE_PRESET;
			bit_q <= '0;
		end else if (tick) begin
			if (pulse_q == fpp_pkg::PULSE_LAST) begin
				pulse_q <= fpp_pkg::PULSE_FIRE;
			end else begin
				pulse_q <= pulse_q + 3'h1;
			end
			if (pulse_q == fpp_pkg::PULSE_ADVANCE_FROM) begin
				bit_q <= bit_q + 1'b1;
			end
		end
	end

	// ****************************************************************
	// Per-bit pulse tally and verify
	// ****************************************************************
	// Each bit owns one five-state frame; repeated pulses on the same bit
	// come from the operator pressing again, and each press pulses every blow bit, verified or not.
	assign bit_line = one_hot(bit_q);
	assign blow_this = |(bit_line & ~pattern_q);
	assign verify_phase = (state_q == fpp_pkg::FPP_RUN) && (pulse_q == fpp_pkg::PULSE_ENABLE);
	assign deselect = (state_q == fpp_pkg::FPP_RUN)
		&& (pulse_q < fpp_pkg::PULSE_ENABLE || pulse_q == fpp_pkg::PULSE_LAST);
	assign fire = (state_q == fpp_pkg::FPP_RUN) && blow_this && !bit_done_q
		&& (pulse_q == fpp_pkg::PULSE_FIRE);

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pulses_q <= fpp_pkg::PULSES_RESET;
			bit_done_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (state_q == fpp_pkg::FPP_IDLE && press) begin
			pulses_q <= fpp_pkg::PULSES_RESET;
			bit_done_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (tick && pulse_q == fpp_pkg::PULSE_ADVANCE_FROM) begin
			pulses_q <= fpp_pkg::PULSES_RESET;
			bit_done_q <= 1'b0;
		end else if (tick && fire) begin
			pulses_q <= pulses_q + 4'h1;
		end else if (tick && verify_phase && blow_this) begin
			if (!(|(out_sync_q & bit_line))) begin
				bit_done_q <= 1'b1;
			end else if (pulses_q >= 4'(PULSE_LIMIT)) begin
				fail_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	// Deselected from the state before the pulse through the state after it,
	// so no edge of the pulse ever meets an enabled chip.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ctrl <= '{addr: '0, cs_low_b: 1'b0, cs_high: 1'b1, vcc_read_low: 1'b0};
		end else begin
			o_ctrl.addr <= addr_q;
			if (deselect) begin
				o_ctrl.cs_low_b <= 1'b1;
				o_ctrl.cs_high <= 1'b0;
			end else begin
				o_ctrl.cs_low_b <= 1'b0;
				o_ctrl.cs_high <= 1'b1;
			end
			o_ctrl.vcc_read_low <= verify_phase;
		end
	end

	// Fuse drive. Outputs that are not being blown are left open.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_drive <= '{pulse: '0, hold_high: '0};
		end else begin
			o_drive.pulse <= fire ? bit_line : '0;
			o_drive.hold_high <= '0;
		end
	end

	// Board decoder. Only the chosen device sees the chip-select swing.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_device_sel_b <= '1;
		end else begin
			o_device_sel_b <= ~DEVICES'(one_hot(BW'(dev_q)));
		end
	end

	// Lamps follow the sensed outputs; a deselected chip floats high.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_indicator <= '1;
		end else begin
			o_indicator <= o_ctrl.cs_low_b ? '1 : out_sync_q;
		end
	end

	assign o_running = (state_q == fpp_pkg::FPP_RUN);
	assign o_fail = fail_q;

endmodule : fpp_programmer

// ===== tb/fpp_programmer_properties.sv
/* Checker for the fuse PROM programmer, bound to its top module.
   Assumes the switches stay steady while a word runs. */
`timescale 1ns/10ps
module fpp_checker #(
	parameter int STEP_CYCLES = 10,
	parameter int DEVICES = 4
) (
	input wire logic i_clock, // Clock.
	input wire logic i_rst_b, // Reset, low.
	input wire logic [7:0] i_pattern_sw, // Pattern switches.
	input wire logic [$clog2(DEVICES)-1:0] i_device_sw, // Device choice.
	input wire fpp_pkg::fpp_ctrl_t o_ctrl, // Control pins.
	input wire logic [DEVICES-1:0] o_device_sel_b, // Device selects.
	input wire fpp_pkg::fpp_drive_t o_drive, // Fuse drive.
	input wire logic [7:0] o_indicator, // Lamps.
	input wire logic o_running // Run flag.
);
	localparam int V_LO = STEP_CYCLES - 1;
	localparam int V_HI = STEP_CYCLES + 1;
	localparam int GAP = 4 * STEP_CYCLES;
	localparam int RUN_MIN = 39 * STEP_CYCLES + 1;
	localparam int RUN_MAX = 40 * STEP_CYCLES;
	logic fire;
	int wc_q, gc_q, rc_q;
	assign fire = |o_drive.pulse;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wc_q <= 0;
			gc_q <= GAP;
			rc_q <= 0;
		end else begin
			wc_q <= fire ? wc_q + 1 : 0;
			gc_q <= fire ? 0 : (gc_q < GAP ? gc_q + 1 : gc_q);
			rc_q <= o_running ? rc_q + 1 : 0;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	sequence s_pulse_end;
		$fell(fire);
	endsequence
	sequence s_verify;
		o_ctrl.vcc_read_low && !o_ctrl.cs_low_b && o_ctrl.cs_high && !fire;
	endsequence
	AST_ONE_PULSE: assert property ($onehot0(o_drive.pulse))
		else $error("two outputs pulsed");
	AST_DESELECTED: assert property (fire |-> o_ctrl.cs_low_b && !o_ctrl.cs_high)
		else $error("pulse while selected");
	AST_PATTERN: assert property (fire |-> (o_drive.pulse & i_pattern_sw) == 8'h00)
		else $error("pulse on a bit kept high");
	AST_WIDTH: assert property ($fell(fire) |-> wc_q == STEP_CYCLES)
		else $error("pulse width wrong");
	AST_DUTY: assert property ($rose(fire) |-> gc_q >= GAP)
		else $error("pulse duty too high");
	AST_RUN_ONLY: assert property (fire |-> o_running)
		else $error("pulse outside run");
	AST_VERIFY: assert property (s_pulse_end |-> ##[V_LO:V_HI] s_verify)
		else $error("verify step missing");
	AST_RUN_LEN: assert property ($fell(o_running) |-> rc_q >= RUN_MIN && rc_q <= RUN_MAX)
		else $error("run length wrong");
	AST_ADDR: assert property (o_running && $past(o_running) |-> $stable(o_ctrl.addr))
		else $error("address moved in run");
	AST_LAMPS: assert property (o_ctrl.cs_low_b [*3] |-> o_indicator == 8'hFF)
		else $error("lamps dark while deselected");
	AST_DEVICE: assert property (o_running && $past(o_running)
		|-> o_device_sel_b == ~(DEVICES'(1) << i_device_sw))
		else $error("wrong device select");
endmodule : fpp_checker
bind fpp_programmer fpp_checker #(.STEP_CYCLES(STEP_CYCLES), .DEVICES(DEVICES)) u_chk (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_pattern_sw(i_pattern_sw),
	.i_device_sw(i_device_sw), .o_ctrl(o_ctrl), .o_device_sel_b(o_device_sel_b),
	.o_drive(o_drive), .o_indicator(o_indicator), .o_running(o_running));

// ===== tb/fpp_prom_model.sv
/* Behavioural fuse PROM on the programmer's far side.
   Assumes it is device 0 on the board decoder and outputs are pulled up. */
`timescale 1ns/10ps
module fpp_prom_model (
	input wire fpp_pkg::fpp_ctrl_t i_ctrl, // Address, selects, supply.
	input wire logic i_dev_sel_b, // Board decoder select, low.
	input wire fpp_pkg::fpp_drive_t i_drive, // Fuse pulses.
	input wire logic [3:0] i_need, // Pulses a fuse needs to open.
	output logic [7:0] o_out // Open-collector outputs.
);
	logic [7:0] mem [1024];
	int hits [1024][8];
	logic [7:0] prv = 8'h00;
	logic desel;
	initial begin
		foreach (mem[a]) mem[a] = 8'hFF;
		foreach (hits[a, b]) hits[a][b] = 0;
	end
	assign desel = i_ctrl.cs_low_b && !i_ctrl.cs_high && !i_dev_sel_b;
	// A blown fuse never heals, so bits only fall.
	always @(i_drive.pulse) begin
		for (int b = 0; b < 8; b++) begin
			if (i_drive.pulse[b] && !prv[b] && desel && !i_ctrl.vcc_read_low) begin
				hits[i_ctrl.addr][b]++;
				if (hits[i_ctrl.addr][b] >= i_need) mem[i_ctrl.addr][b] = 1'b0;
			end
		end
		prv = i_drive.pulse;
	end
	assign o_out = (!i_ctrl.cs_low_b && i_ctrl.cs_high && !i_dev_sel_b) ? mem[i_ctrl.addr] : 8'hFF;
endmodule : fpp_prom_model

// ===== tb/testbench.sv
/* Self-checking bench for the fuse PROM programmer with a PROM model.
   Assumes short step and settle counts so a word runs in at most 400 cycles. */
`timescale 1ns/10ps
module testbench;
	localparam int S = 10;
	logic i_clock = 1'b0;
	logic rst_b, sw, run, fail;
	logic [9:0] addr;
	logic [7:0] pat, prom, lamp;
	logic [1:0] dev;
	logic [3:0] sel_b, need;
	fpp_pkg::fpp_ctrl_t ctrl;
	fpp_pkg::fpp_drive_t drive;
	logic [7:0] ref_mem [1024];
	int rh [1024][8];
	logic [31:0] seed = 32'hADE3;
	int fail_count = 0;
	int check_count = 0;
	always #5 i_clock = ~i_clock;
	fpp_programmer #(.STEP_CYCLES(S), .SETTLE_CYCLES(4), .PULSE_LIMIT(1), .DEVICES(4)) dut (
		.i_clock(i_clock), .i_rst_b(rst_b), .i_program_sw(sw), .i_addr_sw(addr),
		.i_pattern_sw(pat), .i_device_sw(dev), .i_prom_out(prom), .o_ctrl(ctrl),
		.o_device_sel_b(sel_b), .o_drive(drive), .o_indicator(lamp), .o_running(run),
		.o_fail(fail));
	fpp_prom_model u_prom (.i_ctrl(ctrl), .i_dev_sel_b(sel_b[0]), .i_drive(drive),
		.i_need(need), .o_out(prom));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("mismatch %0t got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk
	task automatic run_word(input logic [9:0] a, input logic [7:0] p, input logic [1:0] d,
		input logic [3:0] n);
		logic [7:0] pv, prv, vis;
		int q [$];
		int k;
		@(negedge i_clock);
		addr = a;
		pat = p;
		dev = d;
		need = n;
		repeat (8) @(negedge i_clock);
		chk(lamp, d == 2'd0 ? ref_mem[a] : 8'hFF);
		sw = 1'b1;
		for (k = 0; k < 40 && run !== 1'b1; k++) @(negedge i_clock);
		sw = 1'b0;
		prv = 8'h00;
		for (k = 0; k < 50 * S && run === 1'b1; k++) begin
			@(negedge i_clock);
			pv = drive.pulse;
			if (pv !== 8'h00 && prv === 8'h00)
				for (int b = 0; b < 8; b++) if (pv[b]) q.push_back(b);
			prv = pv;
		end
		if (run !== 1'b0 || k == 0) begin
			$display("mismatch %0t run did not start or end", $time);
			fail_count++;
			test_done();
		end
		for (int b = 0; b < 8; b++) begin
			if (!p[b]) begin
				chk(8'(q.size() > 0 ? q.pop_front() : 9), 8'(b));
				if (d == 2'd0) rh[a][b]++;
				if (d == 2'd0 && rh[a][b] >= n) ref_mem[a][b] = 1'b0;
			end
		end
		chk(8'(q.size()), 8'h00);
		vis = d == 2'd0 ? ref_mem[a] : 8'hFF;
		chk({7'h00, fail}, {7'h00, |(~p & vis)});
		repeat (6) @(negedge i_clock);
		chk(lamp, vis);
	endtask : run_word
	initial begin
		logic [31:0] r;
		rst_b = 1'b0;
		sw = 1'b0;
		addr = 10'h000;
		pat = 8'hFF;
		dev = 2'd0;
		need = 4'h1;
		foreach (ref_mem[a]) ref_mem[a] = 8'hFF;
		foreach (rh[a, b]) rh[a][b] = 0;
		repeat (16) @(negedge i_clock);
		chk({lamp[0], run, fail, sel_b}, 8'h4F);
		rst_b = 1'b1;
		for (int i = 0; i < 6; i++) begin
			r = xs();
			run_word(r[9:0], r[17:10], 2'd0, 4'h1);
		end
		run_word(10'h3FF, 8'h00, 2'd0, 4'h1);
		run_word(10'h001, 8'hFF, 2'd0, 4'h1);
		run_word(10'h155, 8'h7E, 2'd0, 4'h2);
		run_word(10'h155, 8'h7E, 2'd0, 4'h2);
		run_word(10'h2AA, 8'hF0, 2'd2, 4'h1);
		test_done();
	end
endmodule : testbench
